// ===== inc/power_reset_supervisor_regs.vh
`ifndef POWER_RESET_SUPERVISOR_REGS_VH
`define POWER_RESET_SUPERVISOR_REGS_VH
// ==========================================
// Register offsets (byte addresses)
`define PRS_CTRL_ADDR 4'h0
`define PRS_STAT_ADDR 4'h4
`define PRS_IRQ_ADDR 4'h8
`define PRS_MASK_ADDR 4'hC
// ==========================================
// Control fields
`define PRS_CTRL_DET_EN 0
`define PRS_CTRL_EDGE_LO 1
`define PRS_CTRL_EDGE_HI 2
`define PRS_CTRL_MODE_LO 3
`define PRS_CTRL_MODE_HI 4
`define PRS_CTRL_STOP 5
`define PRS_CTRL_STBY 6
`define PRS_CTRL_RST 7'h00
// ==========================================
// Interrupt status fields
`define PRS_IRQ_FALL 0
`define PRS_IRQ_RISE 1
`define PRS_IRQ_RST 2'h0
`define PRS_MASK_RST 2'h0
// ==========================================
// Regulator modes
`define PRS_REG_MAIN 2'h0
`define PRS_REG_LOWPWR 2'h1
`define PRS_REG_PWRDN 2'h2
`define PRS_REG_OFF 2'h3
// ==========================================
// Brownout option codes
`define PRS_BROWN_LVL1 2'h0
`define PRS_BROWN_LVL2 2'h1
`define PRS_BROWN_LVL3 2'h2
`define PRS_BROWN_OFF 2'h3
// ==========================================
// Boot sources
`define PRS_BOOT_FLASH 2'h0
`define PRS_BOOT_SYSMEM 2'h1
`define PRS_BOOT_SRAM 2'h2
// ==========================================
// Timing
`define PRS_OPT_LOAD_NS 800
`define PRS_CLK_NS 100
`define PRS_OPT_LOAD_CYC ((`PRS_OPT_LOAD_NS + `PRS_CLK_NS - 1) / `PRS_CLK_NS)
`endif

// ===== core/power_reset_supervisor.v
// Behaviour
// [RQ1] Internal supervisor is active only while supervisor-enable pin is high.
// [RQ2] Supervisor-enable low ignores internal power-on/down detection; external reset only.
// [RQ3] External supervisor holds reset while main supply stays below threshold.
// [RQ4] Power-on reset held at power-up; option loading starts after threshold crossing.
// [RQ5] Loaded option selects one of three brownout thresholds or disables brownout.
// [RQ6] Reset held while supply below power-on/down or selected brownout threshold.
// [RQ7] Detector interrupt on falling crossing, rising crossing, or both.
// [RQ8] Supply-level detector stays off after reset until software enables it.
// [RQ9] Regulator enabled while bypass pin low; always enabled without that pin.
// [RQ10] Software selects main, low-power on Stop, or power-down on Standby.
// [RQ11] Power-down only on Standby entry; core contents treated as reset on wake.
// [RQ12] Bypass pin high disables regulator; core supply external and unmonitored.
// [RQ13] In regulator-off mode the core-domain reset pin is the core power-on reset.
// [RQ14] In regulator-off mode the core-domain reset pin is never general I/O.
// [RQ15] Core-domain reset pin low blocks debug under reset.
// [RQ16] Boot pins sampled at startup choose flash, system memory or SRAM.
// [RQ17] System reset is OR of all reset requests, released after option loading.
// [RQ18] Boot pin values latched at reset release and held until next reset.
`include "power_reset_supervisor_regs.vh"
module power_reset_supervisor #(
	parameter HAS_BYPASS_PIN = 1
)(
	input wire i_clk,
	input wire i_rstn,
	input wire i_supervisor_enable_pin,
	input wire i_por_ok,
	input wire i_brown_lvl1_ok,
	input wire i_brown_lvl2_ok,
	input wire i_brown_lvl3_ok,
	input wire i_detector_above,
	input wire i_external_reset_pin_n,
	input wire i_regulator_bypass_pin,
	input wire i_core_domain_reset_pin_n,
	input wire [1:0] i_boot_pins,
	input wire [1:0] i_opt_brownout,
	input wire i_sleep_req,
	input wire i_wake,
	input wire [3:0] i_awaddr,
	input wire i_awvalid,
	output reg o_awready,
	input wire [31:0] i_wdata,
	input wire [3:0] i_wstrb,
	input wire i_wvalid,
	output reg o_wready,
	output reg [1:0] o_bresp,
	output reg o_bvalid,
	input wire i_bready,
	input wire [3:0] i_araddr,
	input wire i_arvalid,
	output reg o_arready,
	output reg [31:0] o_rdata,
	output reg [1:0] o_rresp,
	output reg o_rvalid,
	input wire i_rready,
	output reg o_sys_reset,
	output reg o_core_reset,
	output reg o_opt_loading,
	output reg [1:0] o_brown_sel,
	output reg [1:0] o_boot_src,
	output reg o_regulator_on,
	output reg [1:0] o_reg_mode,
	output reg o_core_lost,
	output reg o_debug_allowed,
	output reg o_core_pin_gpio_ok,
	output reg o_irq
);
	// ==========================================
	// Input synchronisers, one generate loop over all pins
	localparam NSYNC = 12;
	wire [NSYNC-1:0] raw_in;
	reg [NSYNC-1:0] meta_q;
	reg [NSYNC-1:0] sync_q;
	assign raw_in = {i_boot_pins, i_core_domain_reset_pin_n, i_regulator_bypass_pin,
		i_external_reset_pin_n, i_detector_above, i_brown_lvl3_ok, i_brown_lvl2_ok,
		i_brown_lvl1_ok, i_por_ok, i_supervisor_enable_pin, i_wake};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi = gi + 1)
		begin : g_sync
			always @(posedge i_clk or negedge i_rstn)
			begin
				if (!i_rstn)
				begin
					meta_q[gi] <= 1'b0;
					sync_q[gi] <= 1'b0;
				end
				else
				begin
					meta_q[gi] <= raw_in[gi];
					sync_q[gi] <= meta_q[gi];
				end
			end
		end
	endgenerate
	wire wake_s = sync_q[0];
	wire sup_en_s = sync_q[1];
	wire por_ok_s = sync_q[2];
	wire [2:0] brown_ok_s = sync_q[5:3];
	wire det_above_s = sync_q[6];
	wire ext_rst_n_s = sync_q[7];
	wire bypass_s = sync_q[8];
	wire core_pin_n_s = sync_q[9];
	wire [1:0] boot_s = sync_q[11:10];

	// ==========================================
	// Register file state
	reg [6:0] ctrl_q;
	reg [1:0] irq_q;
	reg [1:0] mask_q;
	reg det_prev_q;
	reg aw_hold_q;
	reg w_hold_q;
	reg [3:0] awaddr_q;
	reg [31:0] wdata_q;
	reg [3:0] wstrb_q;

	// ==========================================
	// Reset sources
	wire bypass_act = (HAS_BYPASS_PIN != 0) && bypass_s; // [RQ9] [RQ12]
	wire por_req = sup_en_s && !por_ok_s; // [RQ1] [RQ2] [RQ4] [RQ6]
	reg [1:0] brown_opt_q;
	reg brown_req;
	always @*
	begin
		case (brown_opt_q) // [RQ5] [RQ6]
			`PRS_BROWN_LVL1: brown_req = !brown_ok_s[0];
			`PRS_BROWN_LVL2: brown_req = !brown_ok_s[1];
			`PRS_BROWN_LVL3: brown_req = !brown_ok_s[2];
			default: brown_req = 1'b0;
		endcase
	end
	// Brownout only counts once options are loaded and the internal supervisor runs
	wire brown_act = sup_en_s && !o_opt_loading && brown_req;
	// External pin is the only source when supervision is off [RQ2] [RQ3]
	wire ext_req = !ext_rst_n_s;

	// ==========================================
	// Startup sequencer
	localparam ST_POR = 2'h0;
	localparam ST_LOAD = 2'h1;
	localparam ST_RUN = 2'h2;
	localparam CW = 8;
	localparam integer LOAD_CYC_I = `PRS_OPT_LOAD_CYC;
	// Cut to the counter width; CW must cover the load time
	localparam [CW-1:0] LOAD_CYC = LOAD_CYC_I[CW-1:0];
	reg [1:0] st_q;
	reg [CW-1:0] cnt_q;
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			st_q <= ST_POR;
			cnt_q <= {CW{1'b0}};
			o_opt_loading <= 1'b0;
			o_sys_reset <= 1'b1;
			brown_opt_q <= `PRS_BROWN_LVL1;
			o_brown_sel <= `PRS_BROWN_LVL1;
			o_boot_src <= `PRS_BOOT_FLASH;
		end
		else
		begin
			case (st_q)
				ST_POR:
				begin
					o_sys_reset <= 1'b1;
					cnt_q <= {CW{1'b0}};
					if (!por_req)
					begin
						st_q <= ST_LOAD; // [RQ4]
						o_opt_loading <= 1'b1;
					end
				end
				ST_LOAD:
				begin
					o_sys_reset <= 1'b1;
					if (por_req)
					begin
						st_q <= ST_POR;
						o_opt_loading <= 1'b0;
					end
					else if (cnt_q == LOAD_CYC - 8'h01)
					begin
						brown_opt_q <= i_opt_brownout; // [RQ5]
						o_brown_sel <= i_opt_brownout;
						o_opt_loading <= 1'b0;
						st_q <= ST_RUN;
					end
					else
					begin
						cnt_q <= cnt_q + 8'h01;
					end
				end
				ST_RUN:
				begin
					// Combined reset, released only after loading [RQ17]
					o_sys_reset <= por_req || brown_act || ext_req;
					if (o_sys_reset && !(por_req || brown_act || ext_req))
					begin
						// Boot pins frozen at the release edge [RQ16] [RQ18]
						o_boot_src <= (boot_s == 2'h3) ? `PRS_BOOT_SRAM : boot_s;
					end
					if (por_req)
					begin
						st_q <= ST_POR;
						o_sys_reset <= 1'b1;
					end
				end
				default:
					st_q <= ST_POR;
			endcase
		end
	end

	// ==========================================
	// Regulator and core domain
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			o_regulator_on <= 1'b1;
			o_reg_mode <= `PRS_REG_MAIN;
			o_core_lost <= 1'b0;
			o_core_reset <= 1'b1;
			o_debug_allowed <= 1'b0;
			o_core_pin_gpio_ok <= 1'b0;
		end
		else
		begin
			o_regulator_on <= !bypass_act; // [RQ9] [RQ12]
			o_core_pin_gpio_ok <= !bypass_act; // [RQ14]
			// Core pin resets the core only in regulator-off mode [RQ13]
			// Power-down holds the core too, so wake-up starts from reset [RQ11]
			o_core_reset <= o_sys_reset || (bypass_act && !core_pin_n_s) ||
				(o_reg_mode == `PRS_REG_PWRDN);
			o_debug_allowed <= !(bypass_act && !core_pin_n_s); // [RQ15]
			if (bypass_act)
			begin
				o_reg_mode <= `PRS_REG_OFF;
			end
			else if (o_reg_mode == `PRS_REG_OFF)
			begin
				o_reg_mode <= `PRS_REG_MAIN;
			end
			else if (o_reg_mode == `PRS_REG_MAIN && i_sleep_req)
			begin
				// Power-down is reachable only through Standby [RQ10] [RQ11]
				if (ctrl_q[`PRS_CTRL_STBY])
				begin
					o_reg_mode <= `PRS_REG_PWRDN;
					o_core_lost <= 1'b1; // [RQ11]
				end
				else if (ctrl_q[`PRS_CTRL_STOP])
				begin
					o_reg_mode <= `PRS_REG_LOWPWR; // [RQ10]
				end
			end
			else if (o_reg_mode != `PRS_REG_MAIN && wake_s)
			begin
				o_reg_mode <= `PRS_REG_MAIN;
			end
			// Wake from power-down clears on the next system reset
			if (o_sys_reset && o_reg_mode != `PRS_REG_PWRDN)
			begin
				o_core_lost <= 1'b0;
			end
		end
	end

	// ==========================================
	// Supply-level detector events
	wire det_en = ctrl_q[`PRS_CTRL_DET_EN]; // [RQ8]
	wire ev_fall = det_en && det_prev_q && !det_above_s && ctrl_q[`PRS_CTRL_EDGE_LO];
	wire ev_rise = det_en && !det_prev_q && det_above_s && ctrl_q[`PRS_CTRL_EDGE_HI];
	wire [1:0] ev = {ev_rise, ev_fall}; // [RQ7]

	// ==========================================
	// AXI4-Lite slave
	// Ready stays up until a hand-over, so a valid raised early is never stranded
	wire aw_take = i_awvalid && o_awready;
	wire w_take = i_wvalid && o_wready;
	wire ar_take = i_arvalid && o_arready;
	wire [3:0] wa = aw_hold_q ? awaddr_q : i_awaddr;
	wire [31:0] wd = w_hold_q ? wdata_q : i_wdata;
	wire [3:0] ws = w_hold_q ? wstrb_q : i_wstrb;
	wire do_wr = aw_hold_q && w_hold_q && !o_bvalid;
	wire [1:0] clr = (do_wr && wa == `PRS_IRQ_ADDR && ws[0]) ? wd[1:0] : 2'h0;
	always @(posedge i_clk or negedge i_rstn)
	begin
		if (!i_rstn)
		begin
			ctrl_q <= `PRS_CTRL_RST;
			irq_q <= `PRS_IRQ_RST;
			mask_q <= `PRS_MASK_RST;
			det_prev_q <= 1'b0;
			aw_hold_q <= 1'b0;
			w_hold_q <= 1'b0;
			awaddr_q <= 4'h0;
			wdata_q <= 32'h00000000;
			wstrb_q <= 4'h0;
			o_awready <= 1'b0;
			o_wready <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= 2'h0;
			o_arready <= 1'b0;
			o_rvalid <= 1'b0;
			o_rdata <= 32'h00000000;
			o_rresp <= 2'h0;
			o_irq <= 1'b0;
		end
		else
		begin
			det_prev_q <= det_above_s;
			// Set wins over write-one-to-clear
			irq_q <= (irq_q & ~clr) | ev;
			o_irq <= |(((irq_q & ~clr) | ev) & mask_q);
			o_awready <= !aw_hold_q && !aw_take && !o_bvalid;
			o_wready <= !w_hold_q && !w_take && !o_bvalid;
			if (aw_take)
			begin
				aw_hold_q <= 1'b1;
				awaddr_q <= i_awaddr;
			end
			if (w_take)
			begin
				w_hold_q <= 1'b1;
				wdata_q <= i_wdata;
				wstrb_q <= i_wstrb;
			end
			if (o_bvalid && i_bready)
				o_bvalid <= 1'b0;
			if (do_wr)
			begin
				aw_hold_q <= 1'b0;
				w_hold_q <= 1'b0;
				o_awready <= 1'b0;
				o_wready <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= 2'h0;
				if (!ws[0])
					o_bresp <= 2'h0;
				else if (wa == `PRS_CTRL_ADDR)
					ctrl_q <= wd[6:0];
				else if (wa == `PRS_MASK_ADDR)
					mask_q <= wd[1:0];
				else if (wa != `PRS_IRQ_ADDR && wa != `PRS_STAT_ADDR)
					o_bresp <= 2'h2;
			end
			o_arready <= !o_rvalid && !ar_take;
			if (o_rvalid && i_rready)
				o_rvalid <= 1'b0;
			if (ar_take)
			begin
				o_arready <= 1'b0;
				o_rvalid <= 1'b1;
				o_rresp <= 2'h0;
				case (i_araddr)
					`PRS_CTRL_ADDR: o_rdata <= {25'h0, ctrl_q};
					`PRS_STAT_ADDR: o_rdata <= {20'h0, o_boot_src, o_brown_sel, o_reg_mode,
						o_core_lost, det_above_s, bypass_act, sup_en_s, o_opt_loading,
						o_sys_reset};
					`PRS_IRQ_ADDR: o_rdata <= {30'h0, irq_q};
					`PRS_MASK_ADDR: o_rdata <= {30'h0, mask_q};
					default:
					begin
						o_rdata <= 32'h00000000;
						o_rresp <= 2'h2;
					end
				endcase
			end
		end
	end
endmodule

// ===== dv/power_reset_supervisor_monitor.sv
`include "power_reset_supervisor_regs.vh"
module power_reset_supervisor_monitor (
	input wire i_clk,
	input wire i_rstn,
	input wire i_rready,
	input wire o_rvalid,
	input wire [31:0] o_rdata,
	input wire o_sys_reset,
	input wire o_core_reset,
	input wire o_opt_loading,
	input wire [1:0] o_brown_sel,
	input wire [1:0] o_boot_src,
	input wire [1:0] o_reg_mode,
	input wire o_core_lost,
	input wire o_debug_allowed,
	input wire o_core_pin_gpio_ok
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking @(posedge i_clk);
	endclocking
	default disable iff (!i_rstn);
	// ==========================================
	// Checks
	AST_LOAD_SPAN: assert property ($rose(o_opt_loading) |->
		o_opt_loading [*8] ##1 !o_opt_loading) else $error("load span");
	AST_REL_AFTER_LOAD: assert property ($fell(o_sys_reset) |->
		!o_opt_loading && !$past(o_opt_loading)) else $error("early release");
	AST_CORE_IN_SYS: assert property (o_sys_reset |=> o_core_reset)
		else $error("core reset missing");
	AST_NO_GPIO: assert property (o_reg_mode == `PRS_REG_OFF |-> !o_core_pin_gpio_ok)
		else $error("gpio in regulator off");
	AST_NO_DEBUG: assert property (!o_debug_allowed |-> o_core_reset)
		else $error("debug blocked without reset");
	AST_BOOT_HOLD: assert property (!o_sys_reset && !$past(o_sys_reset) |->
		$stable(o_boot_src)) else $error("boot moved");
	AST_BROWN_HOLD: assert property (!o_sys_reset && !$past(o_sys_reset) |->
		$stable(o_brown_sel)) else $error("brownout moved");
	AST_LOST_PWRDN: assert property ($rose(o_core_lost) |->
		o_reg_mode == `PRS_REG_PWRDN || $past(o_reg_mode) == `PRS_REG_PWRDN)
		else $error("loss outside power-down");
	AST_RDATA_HOLD: assert property (o_rvalid && !i_rready |=> o_rvalid && $stable(o_rdata))
		else $error("read data dropped");
endmodule
bind power_reset_supervisor power_reset_supervisor_monitor mon_u (.*);

// ===== dv/supply_partner.sv
module supply_partner (
	input wire [2:0] i_level,
	input wire i_sup_en,
	input wire i_bypass,
	input wire i_core_low,
	input wire i_ext_rst,
	output logic o_por_ok,
	output logic [3:1] o_brown_ok,
	output logic o_det_above,
	output logic o_ext_rst_n,
	output logic o_core_pin_n
);
	timeunit 1ns;
	timeprecision 1ns;
	// Level 0 below power-on, k+1 above brownout k, 5 above detector
	always_comb
	begin
		o_por_ok = i_level > 3'h0;
		o_brown_ok = {i_level > 3'h3, i_level > 3'h2, i_level > 3'h1};
		o_det_above = i_level > 3'h4;
		o_ext_rst_n = !i_ext_rst && !(!i_sup_en && i_level == 3'h0);
		o_core_pin_n = !(i_bypass && i_core_low);
	end
endmodule

// ===== dv/power_reset_supervisor_tb.sv
`include "power_reset_supervisor_regs.vh"
module power_reset_supervisor_tb;
	timeunit 1ns;
	timeprecision 1ns;
	logic i_clk = 1'b0, i_rstn = 1'b0, i_supervisor_enable_pin = 1'b1;
	logic i_regulator_bypass_pin = 1'b0, i_sleep_req = 1'b0, i_wake = 1'b0;
	logic [1:0] i_boot_pins = 2'h0, i_opt_brownout = 2'h0, b, r;
	logic [3:0] i_awaddr = 4'h0, i_araddr = 4'h0, i_wstrb = 4'hF;
	logic [31:0] i_wdata = 32'h0, o_rdata, d;
	logic i_awvalid = 1'b0, i_wvalid = 1'b0, i_bready = 1'b0, i_arvalid = 1'b0, i_rready = 1'b0;
	logic [2:0] level = 3'h5;
	logic core_low = 1'b0, ext_rst = 1'b0;
	wire i_por_ok, i_brown_lvl1_ok, i_brown_lvl2_ok, i_brown_lvl3_ok, i_detector_above;
	wire i_external_reset_pin_n, i_core_domain_reset_pin_n;
	logic o_awready, o_wready, o_bvalid, o_arready, o_rvalid, o_sys_reset, o_core_reset;
	logic o_opt_loading, o_regulator_on, o_core_lost, o_debug_allowed, o_core_pin_gpio_ok, o_irq;
	logic [1:0] o_bresp, o_rresp, o_brown_sel, o_boot_src, o_reg_mode;
	int mismatches = 0, check_count = 0;
	int unsigned seed = 42;
	power_reset_supervisor #(.HAS_BYPASS_PIN(1)) dut_u (.*);
	supply_partner partner_u (.i_level(level), .i_sup_en(i_supervisor_enable_pin),
		.i_bypass(i_regulator_bypass_pin), .i_core_low(core_low), .i_ext_rst(ext_rst),
		.o_por_ok(i_por_ok), .o_brown_ok({i_brown_lvl3_ok, i_brown_lvl2_ok, i_brown_lvl1_ok}),
		.o_det_above(i_detector_above), .o_ext_rst_n(i_external_reset_pin_n),
		.o_core_pin_n(i_core_domain_reset_pin_n));
	always #50 i_clk = ~i_clk;
	// ==========================================
	// Helpers
	function automatic logic [1:0] boot_exp(input logic [1:0] p);
		return (p == 2'h3) ? `PRS_BOOT_SRAM : p;
	endfunction
	function automatic logic [1:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[1:0];
	endfunction
	task automatic w(input int n);
		repeat (n) @(posedge i_clk);
	endtask
	task automatic check(input string what, input logic [31:0] e, input logic [31:0] g);
		check_count++;
		if (g !== e)
		begin
			mismatches++;
			$display("CHECK FAILED %s expected %0h seen %0h", what, e, g);
		end
	endtask
	task automatic wait_rel();
		do @(posedge i_clk); while (o_sys_reset !== 1'b0);
		w(2);
	endtask
	task automatic wr(input logic [3:0] a, input logic [31:0] v);
		i_awaddr <= a;
		i_wdata <= v;
		i_awvalid <= 1'b1;
		i_wvalid <= 1'b1;
		i_bready <= 1'b1;
		do
		begin
			@(posedge i_clk);
			if (o_awready === 1'b1)
				i_awvalid <= 1'b0;
			if (o_wready === 1'b1)
				i_wvalid <= 1'b0;
		end
		while (o_bvalid !== 1'b1);
		b = o_bresp;
		i_bready <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic rd(input logic [3:0] a);
		i_araddr <= a;
		i_arvalid <= 1'b1;
		do @(posedge i_clk); while (o_arready !== 1'b1);
		i_arvalid <= 1'b0;
		do @(posedge i_clk); while (o_rvalid !== 1'b1);
		i_rready <= 1'b1;
		@(posedge i_clk);
		d = o_rdata;
		r = o_rresp;
		i_rready <= 1'b0;
		@(posedge i_clk);
	endtask
	task automatic complete_run();
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("Result: passed");
		else
			$display("Result: failed");
		$finish;
	endtask
	// ==========================================
	// Watchdog, far above the few hundred cycles needed
	initial
	begin
		#2000000;
		mismatches++;
		complete_run();
	end
	// ==========================================
	// Tests
	initial
	begin
		for (int k = 3; k >= 0; k--)
		begin
			i_boot_pins <= k[1:0];
			i_opt_brownout <= k[1:0];
			w(8);
			i_rstn <= 1'b1;
			wait_rel();
			level <= 3'h1;
			w(8);
			check("brown_rst", k != 3, o_sys_reset);
			level <= 3'h5;
			wait_rel();
			check("boot_src", boot_exp(k[1:0]), o_boot_src);
			check("brown_sel", k, o_brown_sel);
			i_boot_pins <= rnd();
			w(6);
			check("boot_hold", boot_exp(k[1:0]), o_boot_src);
			if (k > 0)
				i_rstn <= 1'b0;
		end
		$display("test reset done");
		rd(`PRS_CTRL_ADDR);
		check("ctrl_rst", `PRS_CTRL_RST, d);
		level <= 3'h4;
		w(8);
		rd(`PRS_IRQ_ADDR);
		check("irq_off", `PRS_IRQ_RST, d);
		level <= 3'h5;
		w(4);
		wr(`PRS_CTRL_ADDR, 32'h7);
		check("bresp_ok", 2'h0, b);
		rd(`PRS_STAT_ADDR);
		check("stat", 12'h014, d[11:0]);
		for (int e = 0; e < 2; e++)
		begin
			wr(`PRS_MASK_ADDR, e ? 32'h1 : 32'h3);
			level <= e ? 3'h5 : 3'h4;
			w(8);
			check("irq_pin", e == 0, o_irq);
			rd(`PRS_IRQ_ADDR);
			check("irq_stat", 1 << e, d);
			wr(`PRS_IRQ_ADDR, 1 << e);
			check("irq_clr", 0, o_irq);
		end
		rd(4'h1);
		check("unmapped", 2'h2, r);
		wr(4'h1, 32'hFFFFFFFF);
		check("wr_unmapped", 2'h2, b);
		$display("test detector done");
		for (int m = 1; m < 3; m++)
		begin
			wr(`PRS_CTRL_ADDR, 1 << (m + 4));
			i_sleep_req <= 1'b1;
			@(posedge i_clk);
			i_sleep_req <= 1'b0;
			w(4);
			check("mode", m, o_reg_mode);
			check("lost", m == 2, o_core_lost);
			check("core_pd", m == 2, o_core_reset);
			i_wake <= 1'b1;
			w(6);
			i_wake <= 1'b0;
			check("wake", `PRS_REG_MAIN, o_reg_mode);
			check("core_wake", 0, o_core_reset);
		end
		i_supervisor_enable_pin <= 1'b0;
		level <= 3'h1;
		w(8);
		check("sup_off", 0, o_sys_reset);
		i_supervisor_enable_pin <= 1'b1;
		w(8);
		check("sup_on", 1, o_sys_reset);
		level <= 3'h5;
		ext_rst <= 1'b1;
		w(8);
		check("ext_rst", 1, o_sys_reset);
		ext_rst <= 1'b0;
		wait_rel();
		i_regulator_bypass_pin <= 1'b1;
		core_low <= 1'b1;
		w(8);
		check("reg_on", 0, o_regulator_on);
		check("gpio", 0, o_core_pin_gpio_ok);
		check("core_rst", 1, o_core_reset);
		check("debug", 0, o_debug_allowed);
		i_regulator_bypass_pin <= 1'b0;
		core_low <= 1'b0;
		w(8);
		check("reg_back", 1, o_regulator_on);
		$display("test power done");
		complete_run();
	end
endmodule
